// ### core/sideband_pkg.sv
// Purpose: constants, register map and types for the module sideband control block
// Assumes: 25 MHz core clock, 8-bit management registers addressed by a 2-wire bus
// Notes:   pull-ups on select, reset and low power pins live in the pad ring
`default_nettype none
package sideband_pkg;
    localparam int       CLK_NS         = 40;
    localparam int       RST_MIN_NS     = 10000;
    localparam int       RST_MIN_CYC    = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int       INIT_TIME_US   = 2000;
    localparam int       INIT_CYC       = INIT_TIME_US * 1000 / CLK_NS;
    localparam int       LANES          = 4;
    // 7-bit bus address of the management memory
    localparam logic [6:0] DEV_ADDR     = 7'h50;
    localparam logic [7:0] STATUS_OFS   = 8'h02;
    localparam logic [7:0] FLAG_OFS     = 8'h03;
    localparam logic [7:0] MUTE_OFS     = 8'h64;
    localparam logic [7:0] POWER_OFS    = 8'h5D;
    localparam int       STAT_INIT_BIT  = 0;
    localparam int       PWR_OVR_BIT    = 0;
    localparam int       PWR_SET_BIT    = 1;
    localparam int       PWR_HIGH_BIT   = 2;
    localparam int       MUTE_RX_BIT    = 0;
    localparam int       MUTE_TX_BIT    = 1;
    localparam logic [2:0] POWER_RESET  = 3'h0;
    localparam logic [1:0] MUTE_RESET   = 2'h0;

    typedef enum logic [2:0] {
        st_idle, st_addr, st_addr_ack, st_wdata, st_wack, st_rdata, st_rack
    } bus_state_e;
endpackage : sideband_pkg
`default_nettype wire

// ### core/module_sideband_control.sv
// Purpose: sideband control of a four lane transceiver module: select gated 2-wire
//          management slave, reset and initialisation, interrupt, power and squelch
// Assumes: scl/sda and all pins asynchronous to clk; lane_clk drives lane logic
// Notes:   sda and interrupt are open drain; output enable high pulls the wire low
`default_nettype none
module module_sideband_control #(
    parameter int INIT_CYCLES = sideband_pkg::INIT_CYC
) (
    // core clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // lane clock domain
    input  wire logic             lane_clk,
    input  wire logic             lane_reset,
    // host control pins
    input  wire logic             module_select_n,
    input  wire logic             module_reset_n,
    input  wire logic             low_power_pin,
    output logic                  interrupt_n_o,
    output logic                  interrupt_n_oe,
    // 2-wire management bus
    input  wire logic             scl,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe,
    // lane loss detectors
    input  wire logic [3:0]       rx_los,
    input  wire logic [3:0]       tx_los,
    // lane controls
    output logic      [3:0]       rx_squelch,
    output logic      [3:0]       tx_squelch,
    // power control
    output logic                  low_power_mode,
    output logic                  high_class_enable
);

    typedef struct packed {
        logic [1:0]              scl_s;
        logic [1:0]              sda_s;
        logic [1:0]              sel_s;
        logic [1:0]              rst_s;
        logic [1:0]              lp_s;
        logic [3:0]              txl_s0;
        logic [3:0]              txl_s1;
        logic                    scl_d;
        logic                    sda_d;
        logic                    rst_d;
        sideband_pkg::bus_state_e st;
        logic [3:0]              bitn;
        logic [7:0]              sh;
        logic [7:0]              ptr;
        logic                    first;
        logic                    rw;
        logic                    nack;
        logic                    sda_oe;
        logic [23:0]             low_cnt;
        logic [23:0]             init_cnt;
        logic                    init_pend;
        logic                    done_ack;
        logic                    seen_stat;
        logic                    seen_flag;
        logic [2:0]              pwr;
        logic [1:0]              mute_off;
        logic [3:0]              tx_flag;
        logic                    int_oe;
        logic                    lpm;
        logic                    hce;
    } core_s;

    typedef struct packed {
        logic [1:0] rx_off_s;
        logic [1:0] tx_off_s;
        logic [3:0] rxl_s0;
        logic [3:0] rxl_s1;
        logic [3:0] txl_s0;
        logic [3:0] txl_s1;
        logic [3:0] rx_sq;
        logic [3:0] tx_sq;
    } lane_s;

    core_s q, next_q;
    lane_s l, next_l;

    function automatic logic [7:0] reg_read(input core_s s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            sideband_pkg::STATUS_OFS: d[sideband_pkg::STAT_INIT_BIT] = s.init_pend;
            sideband_pkg::FLAG_OFS:   d[3:0] = s.tx_flag;
            sideband_pkg::POWER_OFS:  d[2:0] = s.pwr;
            sideband_pkg::MUTE_OFS:   d[1:0] = s.mute_off;
            default:                  d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rd_byte;
    logic [3:0] flag_clr;

    always_comb begin
        scl_rise  = q.scl_s[1] && !q.scl_d;
        scl_fall  = !q.scl_s[1] && q.scl_d;
        bus_start = q.scl_s[1] && q.scl_d && q.sda_d && !q.sda_s[1];
        bus_stop  = q.scl_s[1] && q.scl_d && !q.sda_d && q.sda_s[1];
        rd_byte   = reg_read(q, q.ptr);
        flag_clr  = 4'h0;
        next_q    = q;
        // two flop synchronisers on every pin
        next_q.scl_s  = {q.scl_s[0], scl};
        next_q.sda_s  = {q.sda_s[0], sda_i};
        next_q.sel_s  = {q.sel_s[0], module_select_n};
        next_q.rst_s  = {q.rst_s[0], module_reset_n};
        next_q.lp_s   = {q.lp_s[0], low_power_pin};
        next_q.txl_s0 = l.txl_s1;
        next_q.txl_s1 = q.txl_s0;
        next_q.scl_d  = q.scl_s[1];
        next_q.sda_d  = q.sda_s[1];
        next_q.rst_d  = q.rst_s[1];

        // reset pin: time the low pulse, act on the release edge
        if (!q.rst_s[1]) begin
            if (q.low_cnt != 24'hFFFFFF) begin
                next_q.low_cnt = q.low_cnt + 24'h1;
            end
        end else begin
            next_q.low_cnt = 24'h0;
        end
        if (q.init_pend) begin
            if (q.init_cnt >= 24'(INIT_CYCLES - 1)) begin
                next_q.init_pend = 1'b0;
            end else begin
                next_q.init_cnt = q.init_cnt + 24'h1;
            end
        end

        // 2-wire slave
        if (bus_stop || q.sel_s[1]) begin
            next_q.st     = sideband_pkg::st_idle;
            next_q.sda_oe = 1'b0;
        end else if (bus_start) begin
            next_q.st     = sideband_pkg::st_addr;
            next_q.bitn   = 4'h0;
            next_q.sda_oe = 1'b0;
        end else begin
            unique case (q.st)
                sideband_pkg::st_idle: begin
                    next_q.sda_oe = 1'b0;
                end
                sideband_pkg::st_addr,
                sideband_pkg::st_wdata: begin
                    if (scl_rise) begin
                        next_q.sh   = {q.sh[6:0], q.sda_s[1]};
                        next_q.bitn = q.bitn + 4'h1;
                    end else if (scl_fall && q.bitn == 4'h8) begin
                        if (q.st == sideband_pkg::st_addr) begin
                            if (q.sh[7:1] == sideband_pkg::DEV_ADDR) begin
                                next_q.rw     = q.sh[0];
                                next_q.sda_oe = 1'b1;
                                next_q.st     = sideband_pkg::st_addr_ack;
                            end else begin
                                next_q.st = sideband_pkg::st_idle;
                            end
                        end else begin
                            next_q.sda_oe = 1'b1;
                            next_q.st     = sideband_pkg::st_wack;
                            next_q.first  = 1'b0;
                            if (q.first) begin
                                next_q.ptr = q.sh;
                            end else begin
                                next_q.ptr = q.ptr + 8'h1;
                                if (q.ptr == sideband_pkg::POWER_OFS) begin
                                    next_q.pwr = q.sh[2:0];
                                end
                                if (q.ptr == sideband_pkg::MUTE_OFS) begin
                                    next_q.mute_off = q.sh[1:0];
                                end
                            end
                        end
                    end
                end
                sideband_pkg::st_addr_ack,
                sideband_pkg::st_rack,
                sideband_pkg::st_wack: begin
                    if (scl_rise && q.st == sideband_pkg::st_rack) begin
                        next_q.nack = q.sda_s[1];
                    end
                    if (scl_fall) begin
                        next_q.bitn   = 4'h0;
                        next_q.sda_oe = 1'b0;
                        if (q.st == sideband_pkg::st_wack) begin
                            next_q.st = sideband_pkg::st_wdata;
                        end else if (q.st == sideband_pkg::st_addr_ack && !q.rw) begin
                            next_q.st    = sideband_pkg::st_wdata;
                            next_q.first = 1'b1;
                        end else if (q.st == sideband_pkg::st_rack && q.nack) begin
                            next_q.st = sideband_pkg::st_idle;
                        end else begin
                            // load and drive the first bit of the next read byte
                            next_q.st     = sideband_pkg::st_rdata;
                            next_q.sh     = rd_byte;
                            next_q.sda_oe = !rd_byte[7];
                            next_q.ptr    = q.ptr + 8'h1;
                            if (q.ptr == sideband_pkg::STATUS_OFS && !q.init_pend) begin
                                next_q.seen_stat = 1'b1;
                            end
                            if (q.ptr == sideband_pkg::FLAG_OFS) begin
                                next_q.seen_flag = 1'b1;
                                flag_clr         = q.tx_flag;
                            end
                        end
                    end
                end
                sideband_pkg::st_rdata: begin
                    if (scl_fall) begin
                        next_q.bitn = q.bitn + 4'h1;
                        if (q.bitn == 4'h7) begin
                            next_q.sda_oe = 1'b0;
                            next_q.st     = sideband_pkg::st_rack;
                        end else begin
                            next_q.sh     = {q.sh[6:0], 1'b0};
                            next_q.sda_oe = !q.sh[6];
                        end
                    end
                end
                default: begin
                    next_q.st = sideband_pkg::st_idle;
                end
            endcase
        end

        // clear on read, but a new loss in the same cycle survives
        next_q.tx_flag = (q.tx_flag & ~flag_clr) | q.txl_s1;
        if (q.seen_stat && q.seen_flag && !q.init_pend) begin
            next_q.done_ack = 1'b1;
        end

        // long low pulse ends: full reset of settings and a new init interval
        if (q.rst_s[1] && !q.rst_d && q.low_cnt > 24'(sideband_pkg::RST_MIN_CYC)) begin
            next_q.pwr       = sideband_pkg::POWER_RESET;
            next_q.mute_off  = sideband_pkg::MUTE_RESET;
            next_q.tx_flag   = q.txl_s1;
            next_q.init_pend = 1'b1;
            next_q.init_cnt  = 24'h0;
            next_q.done_ack  = 1'b0;
            next_q.seen_stat = 1'b0;
            next_q.seen_flag = 1'b0;
            next_q.st        = sideband_pkg::st_idle;
            next_q.sda_oe    = 1'b0;
        end

        // completion pending or any latched fault pulls the interrupt low
        next_q.int_oe = (!q.init_pend && !q.done_ack) || (|q.tx_flag);

        // override bit picks software power setting, else the pin decides
        next_q.lpm = q.pwr[sideband_pkg::PWR_OVR_BIT] ? q.pwr[sideband_pkg::PWR_SET_BIT]
                                                       : q.lp_s[1];
        next_q.hce = q.pwr[sideband_pkg::PWR_HIGH_BIT] && !next_q.lpm;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q           <= '0;
            q.st        <= sideband_pkg::st_idle;
            q.sel_s     <= 2'h3;
            q.rst_s     <= 2'h3;
            q.rst_d     <= 1'b1;
            q.lp_s      <= 2'h3;
            q.scl_s     <= 2'h3;
            q.sda_s     <= 2'h3;
            q.scl_d     <= 1'b1;
            q.sda_d     <= 1'b1;
            q.init_pend <= 1'b1;
            q.lpm       <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // lane domain: squelch follows loss per lane unless disabled
    always_comb begin
        next_l          = l;
        next_l.rx_off_s = {l.rx_off_s[0], q.mute_off[sideband_pkg::MUTE_RX_BIT]};
        next_l.tx_off_s = {l.tx_off_s[0], q.mute_off[sideband_pkg::MUTE_TX_BIT]};
        next_l.rxl_s0   = rx_los;
        next_l.rxl_s1   = l.rxl_s0;
        next_l.txl_s0   = tx_los;
        next_l.txl_s1   = l.txl_s0;
        next_l.rx_sq    = l.rx_off_s[1] ? 4'h0 : l.rxl_s1;
        next_l.tx_sq    = l.tx_off_s[1] ? 4'h0 : l.txl_s1;
    end

    always_ff @(posedge lane_clk) begin
        if (lane_reset) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign interrupt_n_o     = 1'b0;
    assign interrupt_n_oe    = q.int_oe;
    assign sda_o             = 1'b0;
    assign sda_oe            = q.sda_oe;
    assign rx_squelch        = l.rx_sq;
    assign tx_squelch        = l.tx_sq;
    assign low_power_mode    = q.lpm;
    assign high_class_enable = q.hce;

endmodule : module_sideband_control
`default_nettype wire

// ### tb/module_sideband_control_checker.sv
// Purpose: concurrent checks on the sideband control ports
// Assumes: INIT_CYCLES matches the bound design instance
// Notes:   lane checks allow one extra cycle of synchroniser slip
`default_nettype none
module sideband_checker #(
    parameter int INIT_CYCLES = 20
) (
    // clocks and resets
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       lane_clk,
    input wire logic       lane_reset,
    // pins and bus
    input wire logic       module_select_n,
    input wire logic       interrupt_n_o,
    input wire logic       interrupt_n_oe,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    // lanes and power
    input wire logic [3:0] rx_los,
    input wire logic [3:0] tx_los,
    input wire logic [3:0] rx_squelch,
    input wire logic [3:0] tx_squelch,
    input wire logic       low_power_mode,
    input wire logic       high_class_enable
);
    localparam int LIM = INIT_CYCLES + 8;
    int   cnt;
    logic seen;
    logic los_seen;
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt      <= 0;
            seen     <= 1'b0;
            los_seen <= 1'b0;
        end else begin
            cnt      <= (cnt == LIM) ? cnt : cnt + 1;
            seen     <= seen | interrupt_n_oe;
            los_seen <= los_seen | (|tx_los);
        end
    end
    sequence s_desel;
        module_select_n [*5];
    endsequence
    property p_desel;
        @(posedge clk) disable iff (reset) s_desel |-> !sda_oe;
    endproperty
    a_desel: assert property (p_desel) else $error("sda driven while deselected");
    property p_sel;
        @(posedge clk) disable iff (reset) $rose(sda_oe) |-> !$past(module_select_n, 3);
    endproperty
    a_sel: assert property (p_sel) else $error("sda pulled without select");
    property p_od;
        @(posedge clk) disable iff (reset) interrupt_n_o == 1'b0 && sda_o == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("open drain data not low");
    property p_rst;
        @(posedge clk) disable iff (reset)
            $fell(reset) |-> !interrupt_n_oe && !sda_oe && low_power_mode && !high_class_enable;
    endproperty
    a_rst: assert property (p_rst) else $error("bad output after reset");
    property p_init;
        @(posedge clk) disable iff (reset) cnt == LIM |-> seen;
    endproperty
    a_init: assert property (p_init) else $error("no completion interrupt");
    // a lane fault may legally raise the interrupt early, so only fault-free starts count
    property p_init_quiet;
        @(posedge clk) disable iff (reset) cnt < INIT_CYCLES && !los_seen |-> !interrupt_n_oe;
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("interrupt during init");
    property p_pwr;
        @(posedge clk) disable iff (reset) !(low_power_mode && high_class_enable);
    endproperty
    a_pwr: assert property (p_pwr) else $error("high class in low power");
    property p_rxq;
        @(posedge lane_clk) disable iff (lane_reset)
            (rx_squelch & ~($past(rx_los, 2) | $past(rx_los, 3) | $past(rx_los, 4))) == 4'h0;
    endproperty
    a_rxq: assert property (p_rxq) else $error("rx squelch without loss");
    property p_txq;
        @(posedge lane_clk) disable iff (lane_reset)
            (tx_squelch & ~($past(tx_los, 2) | $past(tx_los, 3) | $past(tx_los, 4))) == 4'h0;
    endproperty
    a_txq: assert property (p_txq) else $error("tx squelch without loss");
endmodule : sideband_checker
bind module_sideband_control sideband_checker #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
    .clk(clk), .reset(reset), .lane_clk(lane_clk), .lane_reset(lane_reset),
    .module_select_n(module_select_n), .interrupt_n_o(interrupt_n_o),
    .interrupt_n_oe(interrupt_n_oe), .sda_o(sda_o), .sda_oe(sda_oe), .rx_los(rx_los),
    .tx_los(tx_los), .rx_squelch(rx_squelch), .tx_squelch(tx_squelch),
    .low_power_mode(low_power_mode), .high_class_enable(high_class_enable));
`default_nettype wire

// ### tb/host_model.sv
// Purpose: host controller mastering the 2-wire bus and the select pin
// Assumes: pulled-up SDA; the device pulls it low when its enable is high
// Notes:   each SCL phase lasts six core cycles, above the four the slave needs
`default_nettype none
module host_model (
    // pacing clock and bus
    input  wire logic clk,
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_low,
    output var logic  select_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ADDR_W = {sideband_pkg::DEV_ADDR, 1'b0};
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        select_n = 1'b0;
    end
    task automatic q;
        repeat (3) @(negedge clk);
    endtask : q
    task automatic sel(input logic s);
        select_n = s;
        repeat (25) @(negedge clk);
    endtask : sel
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        q();
    endtask : bit_io
    // last is the ninth bit driven: 1 releases the line to see the ack, or sends a nack
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r,
                           output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(last, a);
        ack = !a;
    endtask : byte_io
    task automatic start;
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask : stop
    task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0, a1, a2;
        start();
        byte_io(ADDR_W, 1'b1, r, a0);
        byte_io(ofs, 1'b1, r, a1);
        byte_io(d, 1'b1, r, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0, a1, a2, a3;
        start();
        byte_io(ADDR_W, 1'b1, r, a0);
        byte_io(ofs, 1'b1, r, a1);
        start();
        byte_io(ADDR_W | 8'h01, 1'b1, r, a2);
        byte_io(8'hFF, 1'b1, d, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask : reg_rd
    // two byte read: host acks the first byte so the slave auto increments
    task automatic reg_rd2(input logic [7:0] ofs, output logic [7:0] d0, output logic [7:0] d1,
                           output logic ok);
        logic [7:0] r;
        logic       a0, a1, a2, a3;
        start();
        byte_io(ADDR_W, 1'b1, r, a0);
        byte_io(ofs, 1'b1, r, a1);
        start();
        byte_io(ADDR_W | 8'h01, 1'b1, r, a2);
        byte_io(8'hFF, 1'b0, d0, a3);
        byte_io(8'hFF, 1'b1, d1, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask : reg_rd2
endmodule : host_model
`default_nettype wire

// ### tb/tb_module_sideband_control.sv
// Purpose: register level test of the sideband control block
// Assumes: shortened init interval of 1000 core cycles
// Notes:   lane clock runs at 15 ns with an odd offset to the core clock
`default_nettype none
module tb_module_sideband_control;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int INIT = 1000;
    logic       clk = 1'b0, lane_clk = 1'b0, reset = 1'b1, lane_reset = 1'b1;
    logic       module_reset_n = 1'b1, low_power_pin = 1'b1;
    logic [3:0] rx_los = 4'h0, tx_los = 4'h0, rx_squelch, tx_squelch;
    logic       int_o, int_oe, sda_o, sda_oe, scl, sda_low, sel_n, lpm, hce, ok;
    logic [7:0] rd, rd2;
    wire logic  sda = !(sda_low | sda_oe);
    int         n_fail = 0;
    int         samples_checked = 0;
    always #20 clk = ~clk;
    initial begin
        #3.3;
        forever #7.5 lane_clk = ~lane_clk;
    end
    module_sideband_control #(.INIT_CYCLES(INIT)) i_dut (
        .clk(clk), .reset(reset), .lane_clk(lane_clk), .lane_reset(lane_reset),
        .module_select_n(sel_n), .module_reset_n(module_reset_n),
        .low_power_pin(low_power_pin), .interrupt_n_o(int_o), .interrupt_n_oe(int_oe),
        .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .rx_los(rx_los),
        .tx_los(tx_los), .rx_squelch(rx_squelch), .tx_squelch(tx_squelch),
        .low_power_mode(lpm), .high_class_enable(hce));
    host_model i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low), .select_n(sel_n));
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_irq;
        int i;
        for (i = 0; i < INIT + 200 && int_oe !== 1'b1; i++) @(negedge clk);
        chk({7'h0, int_oe}, 8'h01);
        if (int_oe !== 1'b1) print_verdict();
    endtask : wait_irq
    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        i_host.reg_rd(ofs, rd, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rd, exp);
    endtask : rd_chk
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        i_host.reg_wr(ofs, d, ok);
        chk({7'h0, ok}, 8'h01);
    endtask : wr
    initial begin
        logic e;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        lane_reset = 1'b0;
        repeat (4) @(negedge clk);
        chk({7'h0, int_oe}, 8'h00);
        wait_irq();
        rd_chk(sideband_pkg::STATUS_OFS, 8'h00);
        chk({7'h0, int_oe}, 8'h01);
        rd_chk(sideband_pkg::FLAG_OFS, 8'h00);
        chk({7'h0, int_oe}, 8'h00);
        rd_chk(8'h10, 8'h00);
        i_host.sel(1'b1);
        i_host.reg_rd(sideband_pkg::STATUS_OFS, rd, ok);
        chk({6'h0, ok, rd[0]}, 8'h01);
        i_host.sel(1'b0);
        for (int k = 0; k < 16; k++) begin
            low_power_pin = k[3];
            wr(sideband_pkg::POWER_OFS, {5'h0, k[2:0]});
            repeat (4) @(negedge clk);
            e = k[0] ? k[1] : k[3];
            chk({6'h0, lpm, hce}, {6'h0, e, k[2] & !e});
        end
        rd_chk(sideband_pkg::POWER_OFS, 8'h07);
        rx_los = 4'h5;
        tx_los = 4'hA;
        repeat (6) @(negedge clk);
        chk({rx_squelch, tx_squelch}, 8'h5A);
        chk({7'h0, int_oe}, 8'h01);
        tx_los = 4'h0;
        rd_chk(sideband_pkg::FLAG_OFS, 8'h0A);
        chk({7'h0, int_oe}, 8'h00);
        wr(sideband_pkg::MUTE_OFS, 8'h03);
        tx_los = 4'hA;
        repeat (8) @(negedge clk);
        chk({rx_squelch, tx_squelch}, 8'h00);
        tx_los = 4'h0;
        module_reset_n = 1'b0;
        repeat (100) @(negedge clk);
        module_reset_n = 1'b1;
        repeat (10) @(negedge clk);
        rd_chk(sideband_pkg::MUTE_OFS, 8'h03);
        module_reset_n = 1'b0;
        repeat (sideband_pkg::RST_MIN_CYC + 10) @(negedge clk);
        module_reset_n = 1'b1;
        repeat (6) @(negedge clk);
        chk({7'h0, int_oe}, 8'h00);
        rd_chk(sideband_pkg::STATUS_OFS, 8'h01);
        wait_irq();
        rd_chk(sideband_pkg::MUTE_OFS, 8'h00);
        rd_chk(sideband_pkg::POWER_OFS, 8'h00);
        chk({rx_squelch, tx_squelch}, 8'h50);
        i_host.reg_rd2(sideband_pkg::STATUS_OFS, rd, rd2, ok);
        chk({7'h0, ok}, 8'h01);
        chk(rd, 8'h00);
        chk(rd2, 8'h00);
        chk({7'h0, int_oe}, 8'h00);
        print_verdict();
    end
endmodule : tb_module_sideband_control
`default_nettype wire
